// ---- inc/twr_pkg.sv ----
// Package for the timer/watchdog enable and remap controller.
// Assumes a 100 MHz bus clock and byte-addressed register port offsets.
package twr_pkg;
  localparam logic [31:0] CTRL_A_ADDR = 32'h1000_1000;
  localparam logic [31:0] CTRL_B_ADDR = 32'h1001_a000;
  // Peripheral id block: four words at base + 0xfe0 .. 0xfec
  localparam logic [11:0] PID_OFS_0 = 12'hfe0;
  localparam logic [11:0] PID_OFS_3 = 12'hfec;
  localparam logic [31:0] PID_BASE_MASK = 32'hffff_f000;
  // Identification value is arbitrary
  localparam logic [31:0] BUILD_ID = 32'h0000_0001;
  localparam int WDOG_OVR_BIT = 23;
  localparam int TIM_OVR_BIT0 = 16;
  localparam int TIM_SEL_BIT0 = 15;
  localparam int REMAP_STAT_BIT = 9;
  localparam int REMAP_CLR_BIT = 8;
  // Writable bits: override/select pairs and watchdog override
  localparam logic [31:0] CTRL_WMASK = 32'h00ff_8000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic REMAP_RESET = 1'b1;
  typedef struct packed {
    logic wdog;
    logic [3:0] tim;
  } twr_en_type;
endpackage

// ---- hw/twr_ctrl.sv ----
// Two-instance timer/watchdog clock-enable controller with boot remap.
// Assumes both reference clocks are much slower than clk_in.
// Behaviour
// - Bit 23 zero: watchdog enable follows slow reference; one: held high.
// - Override bits 22,20,18,16 force timer 3..0 enables high.
// - Select bits 21,19,17,15 pick slow or 1 MHz reference per timer.
// - Bit 9 of register a reads remap state; writes ignored.
// - Writing one to bit 8 of register a clears remap.
// - Register b: same layout, watchdog 1, timers 7..4, no remap.
// - Instance a drives remap, watchdog 0, timers 0..3; at 0x10001000.
// - Only control and peripheral id registers exist.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module twr_ctrl
  import twr_pkg::*;
(
  input wire logic clk_in, // Bus clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic [31:0] addr_in, // Register byte address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  input wire logic slow_reference_clock_in, // 32.768 kHz reference
  input wire logic timer_reference_clock_in, // 1 MHz reference
  output logic [31:0] rdata_out, // Read data, cycle after strobe
  output logic remap_out, // Boot remap active
  output twr_en_type en_a_out, // Watchdog 0, timers 0..3 enables
  output twr_en_type en_b_out // Watchdog 1, timers 4..7 enables
);
  logic [2:0] slow_sync_r;
  logic [2:0] tim_sync_r;
  logic slow_tick;
  logic tim_tick;
  logic [31:0] ctrl_a_r;
  logic [31:0] ctrl_b_r;
  logic remap_r;
  logic [31:0] rdata_nxt;

  function automatic twr_en_type en_calc(input logic [31:0] c,
                                         input logic s, input logic t);
    twr_en_type e;
    e.wdog = c[WDOG_OVR_BIT] | s;
    for (int i = 0; i < 4; i++) begin
      e.tim[i] = c[TIM_OVR_BIT0 + 2*i] |
                 (c[TIM_SEL_BIT0 + 2*i] ? t : s);
    end
    return e;
  endfunction

  // Stage 0 feeds only stage 1; edge detect looks at stages 1 and 2
  // Reference edges closer than one bus cycle apart merge into one tick
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slow_sync_r <= 3'h0;
      tim_sync_r <= 3'h0;
    end else begin
      slow_sync_r <= {slow_sync_r[1:0], slow_reference_clock_in};
      tim_sync_r <= {tim_sync_r[1:0], timer_reference_clock_in};
    end
  end
  assign slow_tick = slow_sync_r[1] & ~slow_sync_r[2];
  assign tim_tick = tim_sync_r[1] & ~tim_sync_r[2];

  // Reserved bits store nothing; software keeps them by read-modify-write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_a_r <= CTRL_RESET;
      ctrl_b_r <= CTRL_RESET;
    end else if (wr_in) begin
      if (addr_in == CTRL_A_ADDR) begin
        ctrl_a_r <= wdata_in & CTRL_WMASK;
      end
      if (addr_in == CTRL_B_ADDR) begin
        ctrl_b_r <= wdata_in & CTRL_WMASK;
      end
    end
  end

  // Remap is set at reset and only ever cleared by software
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      remap_r <= REMAP_RESET;
    end else if (wr_in && addr_in == CTRL_A_ADDR &&
                 wdata_in[REMAP_CLR_BIT]) begin
      remap_r <= 1'b0;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0;
    if (addr_in == CTRL_A_ADDR) begin
      rdata_nxt = ctrl_a_r;
      rdata_nxt[REMAP_STAT_BIT] = remap_r;
    end else if (addr_in == CTRL_B_ADDR) begin
      rdata_nxt = ctrl_b_r;
    end else if (((addr_in & PID_BASE_MASK) == CTRL_A_ADDR ||
                  (addr_in & PID_BASE_MASK) == CTRL_B_ADDR) &&
                 addr_in[11:0] >= PID_OFS_0 &&
                 addr_in[11:0] <= PID_OFS_3 &&
                 addr_in[1:0] == 2'h0) begin
      rdata_nxt = BUILD_ID;
    end
  end

  // Idle read data is zero so the port can be OR-ed with other slaves
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= rd_in ? rdata_nxt : 32'h0;
    end
  end

  // Registered enables cost one cycle of latency but cannot glitch
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      remap_out <= REMAP_RESET;
      en_a_out <= '0;
      en_b_out <= '0;
    end else begin
      remap_out <= remap_r;
      en_a_out <= en_calc(ctrl_a_r, slow_tick, tim_tick);
      en_b_out <= en_calc(ctrl_b_r, slow_tick, tim_tick);
    end
  end

  // Output checks look one cycle after the inputs that form them; a_remap_clear looks two cycles after the write
  a_remap_clear: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    wr_in && addr_in == CTRL_A_ADDR && wdata_in[REMAP_CLR_BIT]
    |=> ##1 !remap_out)
    else $error("remap not cleared");
  a_remap_sticky: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !remap_r |=> !remap_r)
    else $error("remap returned");
  a_remap_ro_bit: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    wr_in && addr_in == CTRL_A_ADDR && !wdata_in[REMAP_CLR_BIT]
    |=> remap_r == $past(remap_r))
    else $error("remap changed without clear request");
  a_b_no_clear: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    wr_in && addr_in == CTRL_B_ADDR
    |=> remap_r == $past(remap_r))
    else $error("register b write changed remap");
  a_remap_drive: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !remap_r
    |=> !remap_out)
    else $error("remap output does not follow state");
  a_wdog_force: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ctrl_a_r[WDOG_OVR_BIT]
    |=> en_a_out.wdog)
    else $error("watchdog enable not forced");
  a_wdog_slow: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !ctrl_a_r[WDOG_OVR_BIT]
    |=> en_a_out.wdog == $past(slow_tick))
    else $error("watchdog enable source wrong");
  a_wdog_b_force: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ctrl_b_r[WDOG_OVR_BIT]
    |=> en_b_out.wdog)
    else $error("watchdog 1 enable not forced");
  a_wdog_b_slow: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !ctrl_b_r[WDOG_OVR_BIT]
    |=> en_b_out.wdog == $past(slow_tick))
    else $error("watchdog 1 enable source wrong");
  a_tim_force: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ctrl_b_r[TIM_OVR_BIT0 + 6]
    |=> en_b_out.tim[3])
    else $error("timer 7 enable not forced");
  a_tim3_force: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ctrl_a_r[TIM_OVR_BIT0 + 6]
    |=> en_a_out.tim[3])
    else $error("timer 3 enable not forced");
  a_tim_select: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !ctrl_a_r[TIM_OVR_BIT0] && ctrl_a_r[TIM_SEL_BIT0]
    |=> en_a_out.tim[0] == $past(tim_tick))
    else $error("timer 0 reference wrong");
  a_tim_slow: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !ctrl_a_r[TIM_OVR_BIT0 + 2] && !ctrl_a_r[TIM_SEL_BIT0 + 2]
    |=> en_a_out.tim[1] == $past(slow_tick))
    else $error("timer 1 slow reference wrong");
  a_b_tim_select: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !ctrl_b_r[TIM_OVR_BIT0] && ctrl_b_r[TIM_SEL_BIT0]
    |=> en_b_out.tim[0] == $past(tim_tick))
    else $error("timer 4 reference wrong");
  a_tick_pulse: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    tim_tick
    |=> !tim_tick)
    else $error("tick longer than one cycle");
  a_stat_read: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == CTRL_A_ADDR
    |=> rdata_out[REMAP_STAT_BIT] == $past(remap_r))
    else $error("remap status read wrong");
  a_b_no_remap: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == CTRL_B_ADDR
    |=> rdata_out[9:8] == 2'h0)
    else $error("register b remap bits set");
  a_b_reserved: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == CTRL_B_ADDR
    |=> (rdata_out & ~CTRL_WMASK) == 32'h0)
    else $error("register b reserved bits set");
  a_pid_read: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    rd_in && (addr_in & PID_BASE_MASK) == CTRL_B_ADDR &&
    addr_in[11:0] == PID_OFS_3 |=> rdata_out == BUILD_ID)
    else $error("identification read wrong");
  a_unmapped: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    rd_in && addr_in == 32'h1000_2000
    |=> rdata_out == 32'h0)
    else $error("unmapped read nonzero");
endmodule // twr_ctrl
`default_nettype wire

// ---- testbench/twr_refs.sv ----
// Free-running reference clock sources for the enable controller.
// Assumes 1 ns time units; both clocks are unrelated to the bus clock.
`timescale 1ns/1ps
`default_nettype none
module twr_refs (
  output logic slow_ref_out, // 32.768 kHz reference
  output logic tim_ref_out // 1 MHz reference
);
  initial begin
    slow_ref_out = 1'b0;
    forever #15259 slow_ref_out = ~slow_ref_out;
  end
  initial begin
    tim_ref_out = 1'b0;
    forever #500 tim_ref_out = ~tim_ref_out;
  end
endmodule // twr_refs
`default_nettype wire

// ---- testbench/twr_ctrl_tb.sv ----
// Self-checking bench for the enable and remap controller.
// Assumes twr_refs supplies both reference clocks.
`timescale 1ns/1ps
`default_nettype none
module twr_ctrl_tb;
  import twr_pkg::*;
  logic clk_in = 0, nrst_in = 0, wr = 0, rd = 0, sref, tref, remap;
  logic [31:0] addr = 0, wdata = 0, rdata;
  twr_en_type en_a, en_b;
  int n_mismatch = 0, num_checks = 0, cyc = 0, na, nb, nz, nw;
  always #5 clk_in = ~clk_in;
  twr_refs twr_refs_inst (.slow_ref_out(sref), .tim_ref_out(tref));
  twr_ctrl twr_ctrl_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .slow_reference_clock_in(sref), .timer_reference_clock_in(tref),
    .rdata_out(rdata), .remap_out(remap), .en_a_out(en_a),
    .en_b_out(en_b));
  task chk(string n, logic [31:0] v, logic [31:0] e);
    num_checks++;
    if (v !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, v);
    end
  endtask
  task wr32(logic [31:0] a, logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task rd32(logic [31:0] a, logic [31:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  // Read-modify-write: reserved bits go back exactly as they were read
  task rmw(logic [31:0] a, logic [31:0] s);
    logic [31:0] v;
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk_in);
    wdata <= v | s;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard: the whole sequence needs about 2040 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      n_mismatch++;
      results;
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1 chk("remap", {31'h0, remap}, 32'h1);
    rd32(CTRL_A_ADDR, 32'h0000_0200);
    $display("test reset done");
    rmw(CTRL_B_ADDR, 32'h00ff_8000);
    rd32(CTRL_A_ADDR, 32'h0000_0200);
    rmw(CTRL_A_ADDR, 32'h00ff_8100);
    @(posedge clk_in);
    #1 chk("en_a", {27'h0, en_a}, 32'h1f);
    chk("en_b", {27'h0, en_b}, 32'h1f);
    chk("remap", {31'h0, remap}, 32'h0);
    rd32(CTRL_A_ADDR, CTRL_WMASK);
    rd32(CTRL_B_ADDR, CTRL_WMASK);
    rd32(32'h1000_2000, 32'h0);
    rd32({CTRL_B_ADDR[31:12], PID_OFS_3}, BUILD_ID);
    $display("test registers done");
    wr32(CTRL_A_ADDR, 32'h0000_8000);
    wr32(CTRL_B_ADDR, 32'h0000_8000);
    rd32(CTRL_A_ADDR, 32'h0000_8000);
    na = 0;
    nb = 0;
    nz = 0;
    nw = 0;
    // 2000 cycles hold 20 fast rises and only the first slow rise
    repeat (2000) begin
      @(posedge clk_in);
      #1 na += int'(en_a.tim[0] === 1'b1);
      nb += int'(en_b.tim[0] === 1'b1);
      nz += int'(en_a.tim[1] === 1'b1);
      nw += int'(en_a.wdog === 1'b1);
    end
    chk("tim0", {31'h0, na >= 19 && na <= 21}, 32'h1);
    chk("tim4", {31'h0, nb >= 19 && nb <= 21}, 32'h1);
    chk("tim1", {31'h0, nz == 1}, 32'h1);
    chk("wdog0", {31'h0, nw == 1}, 32'h1);
    $display("test enables done");
    results;
  end
endmodule // twr_ctrl_tb
`default_nettype wire
